// ### logic/self_test_defines.svh
// Constants for the terminal diagnostic self-test sequencer
`ifndef SELF_TEST_DEFINES_SVH
`define SELF_TEST_DEFINES_SVH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define CLK_HZ            50000000
`define CHAR_PHASE_S      90
`define SETTLE_US         10
`define SETTLE_CYCLES     ((`SETTLE_US * `CLK_HZ) / 1000000)
`define BEEP_MS           200
// Divide first: the plain product overflows 32-bit integer arithmetic
`define BEEP_CYCLES       (`BEEP_MS * (`CLK_HZ / 1000))

// ----------------------------------------
// Memory and PROM geometry
// ----------------------------------------
`define RAM_AW            8
`define RAM_LAST          8'hFF
`define ROM_AW            12
`define ROM_LAST          12'hFFF
`define ROM_SUM_GOOD      8'h00
`define NV_SIGNATURE      16'hA55A

// ----------------------------------------
// Error characters (ASCII)
// ----------------------------------------
`define ERR_CHAR_RAM      8'h30
`define ERR_ATTR_RAM      8'h31
`define ERR_FONT_RAM      8'h32
`define ERR_PROM_SUM      8'h50
`define ERR_SETUP_LOST    8'h4B
`define ERR_PAR_ACK       8'h64
`define ERR_PAR_BUSY      8'h62
`define ERR_PAR_PE        8'h63
`define ERR_PAR_ERROR     8'h61
`define ERR_SER_TXD       8'h78
`define ERR_SER_RTS       8'h41
`define ERR_SER_DTR       8'h63

// ----------------------------------------
// Loopback path numbering
// ----------------------------------------
`define PATH_TXD          3'h0
`define PATH_RTS          3'h1
`define PATH_DTR          3'h2
`define PATH_ACK          3'h3
`define PATH_BUSY         3'h4
`define PATH_PE           3'h5
`define PATH_ERROR        3'h6
`define PATH_COUNT        7

`endif

// ### logic/self_test_pkg.sv
// Types for the terminal diagnostic self-test sequencer
package self_test_pkg;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_MEMWR = 3'b001,
		ST_MEMRD = 3'b010,
		ST_ROM   = 3'b011,
		ST_NV    = 3'b100,
		ST_LOOP  = 3'b101,
		ST_LWAIT = 3'b110,
		ST_FAIL  = 3'b111
	} test_state_e;

	typedef enum logic [1:0] {
		LC_IDLE = 2'b00,
		LC_LOW  = 2'b01,
		LC_HIGH = 2'b10
	} loop_state_e;

	typedef enum logic [1:0] {
		RAM_CHAR = 2'b00,
		RAM_ATTR = 2'b01,
		RAM_FONT = 2'b10
	} ram_sel_e;

endpackage

// ### logic/loop_path_check.sv
// One loopback path check: drives low then high and compares the return
`timescale 1ns/1ps
`default_nettype none
`include "self_test_defines.svh"

module loop_path_check (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Control
	input  wire logic start,
	output logic      done,
	output logic      pass,
	// Path
	input  wire logic loopIn,
	output logic      driveLevel
);

	localparam logic [15:0] SETTLE = 16'(`SETTLE_CYCLES);

	self_test_pkg::loop_state_e stateReg;
	logic [15:0]                settleReg;
	logic                       lowOkReg;

	wire settled = (settleReg == SETTLE - 16'h0001);

	// Both levels must return before the path is called good
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stateReg   <= self_test_pkg::LC_IDLE;
			settleReg  <= 16'h0000;
			lowOkReg   <= 1'b0;
			driveLevel <= 1'b0;
			done       <= 1'b0;
			pass       <= 1'b0;
		end else begin
			done <= 1'b0;
			case (stateReg)
				self_test_pkg::LC_IDLE: begin
					settleReg <= 16'h0000;
					if (start) begin
						driveLevel <= 1'b0;
						stateReg   <= self_test_pkg::LC_LOW;
					end
				end
				self_test_pkg::LC_LOW: begin
					settleReg <= settled ? 16'h0000 : settleReg + 16'h0001;
					if (settled) begin
						lowOkReg   <= ~loopIn;
						driveLevel <= 1'b1;
						stateReg   <= self_test_pkg::LC_HIGH;
					end
				end
				self_test_pkg::LC_HIGH: begin
					settleReg <= settled ? 16'h0000 : settleReg + 16'h0001;
					if (settled) begin
						pass       <= lowOkReg & loopIn;
						done       <= 1'b1;
						driveLevel <= 1'b0;
						stateReg   <= self_test_pkg::LC_IDLE;
					end
				end
				default: stateReg <= self_test_pkg::LC_IDLE;
			endcase
		end
	end

endmodule
`default_nettype wire

// ### logic/terminal_diagnostic_self_test.sv
// Diagnostic self-test sequencer for a video display terminal
//
// Function
// - The test starts only while the terminal is in setup mode.
// - Each pass runs port loopback, RAM write/read, PROM checksum and setup memory checks.
// - Passes repeat without end until stopped, unless a check fails.
// - The first failure halts the test, sounds the beeper and shows one error character.
// - Character, attribute and font RAM failures report 0, 1 and 2.
// - A PROM checksum mismatch reports P and lost setup memory reports K.
// - Data bit 0 or 1 must return on acknowledge, else code d.
// - Data bit 2 or 3 must return on busy, else its own distinct code.
// - Data bits 4/5 return on paper-empty, code c as for DTR, and 6/7 on error, code a.
// - The serial plug links TXD-RXD, RTS-CTS, DTR-DCD, reported as x, A and c.
// - The screen shows a walking character pattern for about 90 s, then attributes.
`timescale 1ns/1ps
`default_nettype none
`include "self_test_defines.svh"

module terminal_diagnostic_self_test #(
	parameter logic [63:0] CHAR_PHASE_CYCLES = 64'(`CHAR_PHASE_S) * 64'(`CLK_HZ),
	parameter logic [31:0] BEEP_CYCLES       = 32'(`BEEP_CYCLES)
) (
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                rst_n,
	// Operator control
	input  wire logic                setupMode,
	input  wire logic                startReq,
	input  wire logic                stopReq,
	// Status
	output logic                     running,
	output logic                     failed,
	output logic [7:0]               errCode,
	output logic                     beep,
	output logic                     attrPattern,
	// Display RAM port (read data one cycle after address)
	output logic [1:0]               ramSel,
	output logic                     ramWe,
	output logic [`RAM_AW-1:0]       ramAddr,
	output logic [7:0]               ramWdata,
	input  wire logic [7:0]          ramRdata,
	// Code PROM port (data one cycle after address)
	output logic [`ROM_AW-1:0]       romAddr,
	input  wire logic [7:0]          romData,
	// Setup memory signature
	input  wire logic [15:0]         nvSignature,
	// Serial port pins
	output logic                     txd,
	output logic                     rts,
	output logic                     dtr,
	input  wire logic                rxd,
	input  wire logic                cts,
	input  wire logic                dcd,
	// Auxiliary parallel port pins
	output logic [7:0]               parData,
	input  wire logic                ackIn,
	input  wire logic                busyIn,
	input  wire logic                paperEmptyIn,
	input  wire logic                errorIn
);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [`PATH_COUNT-1:0] pinMetaReg;
	logic [`PATH_COUNT-1:0] pinSyncReg;
	wire  [`PATH_COUNT-1:0] pinRaw = {errorIn, paperEmptyIn, busyIn, ackIn, dcd, cts, rxd};
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pinMetaReg <= '0;
			pinSyncReg <= '0;
		end else begin
			pinMetaReg <= pinRaw;
			pinSyncReg <= pinMetaReg;
		end
	end

	// ----------------------------------------
	// Sequencer state
	// ----------------------------------------
	self_test_pkg::test_state_e stateReg;
	logic [1:0]                 ramSelReg;
	logic [`RAM_AW-1:0]         addrReg;
	logic                       phaseReg;
	logic [7:0]                 seedReg;
	logic [`ROM_AW-1:0]         romAddrReg;
	logic [7:0]                 sumReg;
	logic [2:0]                 pathReg;
	logic                       loopStartReg;
	logic [63:0]                phaseCntReg;
	logic [31:0]                beepCntReg;
	wire       loopDone;
	wire       loopPass;
	wire       loopDrive;
	wire [7:0] expData  = addrReg ^ seedReg;
	wire       ramLast  = (addrReg == `RAM_LAST);
	wire       romLast  = (romAddrReg == `ROM_LAST);
	wire       pathLast = (pathReg == 3'(`PATH_COUNT - 1));
	wire       loopIn   = pinSyncReg[pathReg];
	wire       active   = (stateReg != self_test_pkg::ST_IDLE)
	                    && (stateReg != self_test_pkg::ST_FAIL);
	wire [7:0] ramErr = (ramSelReg == self_test_pkg::RAM_CHAR) ? `ERR_CHAR_RAM :
	                    (ramSelReg == self_test_pkg::RAM_ATTR) ? `ERR_ATTR_RAM :
	                                                             `ERR_FONT_RAM;
	wire [7:0] pathErr = (pathReg == `PATH_TXD)  ? `ERR_SER_TXD   :
	                     (pathReg == `PATH_RTS)  ? `ERR_SER_RTS   :
	                     (pathReg == `PATH_DTR)  ? `ERR_SER_DTR   :
	                     (pathReg == `PATH_ACK)  ? `ERR_PAR_ACK   :
	                     (pathReg == `PATH_BUSY) ? `ERR_PAR_BUSY  :
	                     (pathReg == `PATH_PE)   ? `ERR_PAR_PE    :
	                                               `ERR_PAR_ERROR;
	loop_path_check loopCheck (
		.clk        (clk),
		.rst_n      (rst_n),
		.start      (loopStartReg),
		.done       (loopDone),
		.pass       (loopPass),
		.loopIn     (loopIn),
		.driveLevel (loopDrive)
	);

	// ----------------------------------------
	// Check sequence
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stateReg     <= self_test_pkg::ST_IDLE;
			ramSelReg    <= 2'b00;
			addrReg      <= '0;
			phaseReg     <= 1'b0;
			seedReg      <= 8'h00;
			romAddrReg   <= '0;
			sumReg       <= 8'h00;
			pathReg      <= 3'h0;
			loopStartReg <= 1'b0;
			errCode      <= 8'h00;
		end else begin
			loopStartReg <= 1'b0;
			if (stopReq && stateReg != self_test_pkg::ST_IDLE) begin
				stateReg <= self_test_pkg::ST_IDLE;
			end else begin
				case (stateReg)
					self_test_pkg::ST_IDLE: begin
						if (startReq && setupMode) begin
							errCode      <= 8'h00;
							pathReg      <= 3'h0;
							loopStartReg <= 1'b1;
							stateReg     <= self_test_pkg::ST_LOOP;
						end
					end
					self_test_pkg::ST_LOOP: begin
						if (loopDone && !loopPass) begin
							errCode  <= pathErr;
							stateReg <= self_test_pkg::ST_FAIL;
						end else if (loopDone && pathLast) begin
							ramSelReg <= self_test_pkg::RAM_CHAR;
							addrReg   <= '0;
							stateReg  <= self_test_pkg::ST_MEMWR;
						end else if (loopDone) begin
							pathReg  <= pathReg + 3'h1;
							stateReg <= self_test_pkg::ST_LWAIT;
						end
					end
					self_test_pkg::ST_LWAIT: begin
						// Gap lets the registered pin drive clear the old path
						loopStartReg <= 1'b1;
						stateReg     <= self_test_pkg::ST_LOOP;
					end
					self_test_pkg::ST_MEMWR: begin
						addrReg <= addrReg + 1'b1;
						if (ramLast) begin
							phaseReg <= 1'b0;
							stateReg <= self_test_pkg::ST_MEMRD;
						end
					end
					self_test_pkg::ST_MEMRD: begin
						phaseReg <= ~phaseReg;
						if (phaseReg) begin
							addrReg <= addrReg + 1'b1;
							if (ramRdata != expData) begin
								errCode  <= ramErr;
								stateReg <= self_test_pkg::ST_FAIL;
							end else if (ramLast && ramSelReg == self_test_pkg::RAM_FONT) begin
								romAddrReg <= '0;
								sumReg     <= 8'h00;
								stateReg   <= self_test_pkg::ST_ROM;
							end else if (ramLast) begin
								ramSelReg <= ramSelReg + 2'b01;
								stateReg  <= self_test_pkg::ST_MEMWR;
							end
						end
					end
					self_test_pkg::ST_ROM: begin
						phaseReg <= ~phaseReg;
						if (phaseReg) begin
							sumReg     <= sumReg + romData;
							romAddrReg <= romAddrReg + 1'b1;
							if (romLast) begin
								stateReg <= self_test_pkg::ST_NV;
							end
						end
					end
					self_test_pkg::ST_NV: begin
						if (sumReg != `ROM_SUM_GOOD) begin
							errCode  <= `ERR_PROM_SUM;
							stateReg <= self_test_pkg::ST_FAIL;
						end else if (nvSignature != `NV_SIGNATURE) begin
							errCode  <= `ERR_SETUP_LOST;
							stateReg <= self_test_pkg::ST_FAIL;
						end else begin
							seedReg      <= seedReg + 8'h01;
							pathReg      <= 3'h0;
							loopStartReg <= 1'b1;
							stateReg     <= self_test_pkg::ST_LOOP;
						end
					end
					self_test_pkg::ST_FAIL: stateReg <= self_test_pkg::ST_FAIL;
					default: stateReg <= self_test_pkg::ST_IDLE;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Screen pattern phase and beeper
	// ----------------------------------------
	wire phaseDone = (phaseCntReg >= CHAR_PHASE_CYCLES - 64'h1);
	wire failEntry = (stateReg != self_test_pkg::ST_FAIL) && !stopReq
	               && (((stateReg == self_test_pkg::ST_LOOP) && loopDone && !loopPass)
	               || ((stateReg == self_test_pkg::ST_MEMRD) && phaseReg
	                   && (ramRdata != expData))
	               || ((stateReg == self_test_pkg::ST_NV)
	                   && ((sumReg != `ROM_SUM_GOOD) || (nvSignature != `NV_SIGNATURE))));
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phaseCntReg <= 64'h0;
			attrPattern <= 1'b0;
			beepCntReg  <= 32'h0;
			beep        <= 1'b0;
		end else begin
			if (!active) begin
				phaseCntReg <= 64'h0;
				attrPattern <= 1'b0;
			end else if (phaseDone) begin
				attrPattern <= 1'b1;
			end else begin
				phaseCntReg <= phaseCntReg + 64'h1;
			end
			if (failEntry) begin
				beepCntReg <= BEEP_CYCLES;
				beep       <= 1'b1;
			end else if (beepCntReg > 32'h1) begin
				beepCntReg <= beepCntReg - 32'h1;
			end else begin
				beepCntReg <= 32'h0;
				beep       <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Output drive
	// ----------------------------------------
	wire looping = (stateReg == self_test_pkg::ST_LOOP);
	wire [7:0] parNext;
	// Each data pair drives together so either plug variant loops back
	genvar k;
	for (k = 0; k < 4; k = k + 1) begin : gParPair
		assign parNext[2*k+1:2*k] = (looping && pathReg == 3'(`PATH_ACK + k))
		                          ? {2{loopDrive}} : 2'b00;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			txd     <= 1'b1;
			rts     <= 1'b0;
			dtr     <= 1'b0;
			parData <= 8'h00;
		end else begin
			txd     <= (looping && pathReg == `PATH_TXD) ? loopDrive : 1'b1;
			rts     <= looping && pathReg == `PATH_RTS && loopDrive;
			dtr     <= looping && pathReg == `PATH_DTR && loopDrive;
			parData <= parNext;
		end
	end
	assign running  = active;
	assign failed   = (stateReg == self_test_pkg::ST_FAIL);
	assign ramSel   = ramSelReg;
	assign ramWe    = (stateReg == self_test_pkg::ST_MEMWR);
	assign ramAddr  = addrReg;
	assign ramWdata = expData;
	assign romAddr  = romAddrReg;

endmodule
`default_nettype wire

// ### dv/loopback_plug_model.sv
// Loopback plug model for the serial and auxiliary parallel ports
`timescale 1ns/1ps
`default_nettype none

module loopback_plug_model (
	// Plug setup
	input  wire logic       oddPlug,
	input  wire logic [3:0] breakPath,
	input  wire logic       stuckLvl,
	// Device outputs
	input  wire logic       txd,
	input  wire logic       rts,
	input  wire logic       dtr,
	input  wire logic [7:0] parData,
	// Returns to the device
	output logic            rxd,
	output logic            cts,
	output logic            dcd,
	output logic            ackIn,
	output logic            busyIn,
	output logic            paperEmptyIn,
	output logic            errorIn
);
	// A broken path sticks at one level, so only one drive phase can catch it
	function automatic logic ret(input logic drv, input logic [3:0] p);
		ret = (breakPath == p) ? stuckLvl : drv;
	endfunction

	assign rxd = ret(txd, 4'h0);
	assign cts = ret(rts, 4'h1);
	assign dcd = ret(dtr, 4'h2);
	// Strobe is grounded on both variants and has no pin here
	assign ackIn = ret(oddPlug ? parData[1] : parData[0], 4'h3);
	assign busyIn = ret(oddPlug ? parData[3] : parData[2], 4'h4);
	assign paperEmptyIn = ret(oddPlug ? parData[5] : parData[4], 4'h5);
	assign errorIn = ret(oddPlug ? parData[7] : parData[6], 4'h6);
endmodule
`default_nettype wire

// ### dv/self_test_monitor.sv
// Concurrent checks on the self-test sequencer ports
`timescale 1ns/1ps
`default_nettype none
`include "self_test_defines.svh"

module self_test_checker #(
	parameter logic [63:0] CHAR_PHASE_CYCLES = 64'(`CHAR_PHASE_S) * 64'(`CLK_HZ),
	parameter logic [31:0] BEEP_CYCLES       = 32'(`BEEP_CYCLES)
) (
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic       setupMode,
	input wire logic       startReq,
	input wire logic       stopReq,
	input wire logic       running,
	input wire logic       failed,
	input wire logic [7:0] errCode,
	input wire logic       beep,
	input wire logic       attrPattern,
	input wire logic       txd,
	input wire logic [7:0] parData
);
	logic [31:0] beepCnt;
	logic [63:0] runCnt;
	wire logic   idle;

	assign idle = !running && !failed;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			beepCnt <= 32'h0;
			runCnt <= 64'h0;
		end else begin
			beepCnt <= beep ? beepCnt + 32'h1 : 32'h0;
			runCnt <= running ? runCnt + 64'h1 : 64'h0;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_startTaken;
		idle && startReq && setupMode && !stopReq;
	endsequence
	sequence s_driveLow;
		!txd [*8];
	endsequence

	a_start_runs: assert property (s_startTaken |=> running)
		else $error("start request not taken");
	a_setup_gate: assert property (idle && !setupMode |=> idle)
		else $error("test left idle outside setup mode");
	a_stop_clears: assert property ((running || failed) && stopReq |=> idle)
		else $error("stop did not return to idle");
	a_fail_halts: assert property ($rose(failed) |-> beep && !running && errCode != 8'h00)
		else $error("failure without halt, beep or code");
	a_fail_holds: assert property (failed && !stopReq |=> failed && $stable(errCode))
		else $error("failure code not held");
	a_code_known: assert property ($rose(failed) |-> errCode inside {`ERR_CHAR_RAM,
		`ERR_ATTR_RAM, `ERR_FONT_RAM, `ERR_PROM_SUM, `ERR_SETUP_LOST, `ERR_PAR_ACK,
		`ERR_PAR_BUSY, `ERR_PAR_PE, `ERR_PAR_ERROR, `ERR_SER_TXD, `ERR_SER_RTS, `ERR_SER_DTR})
		else $error("unknown failure code");
	a_beep_length: assert property ($fell(beep) && failed |-> beepCnt == BEEP_CYCLES)
		else $error("beep length wrong");
	a_low_first: assert property (s_startTaken |-> ##[1:3] s_driveLow)
		else $error("first loopback phase not driven low");
	a_attr_timing: assert property ($rose(attrPattern) |->
		runCnt + 64'h2 >= CHAR_PHASE_CYCLES && runCnt <= CHAR_PHASE_CYCLES + 64'h2)
		else $error("attribute pattern at wrong time");
	a_char_first: assert property (running && runCnt + 64'h3 < CHAR_PHASE_CYCLES |-> !attrPattern)
		else $error("attribute pattern too early");
	a_pair_drive: assert property (parData[0] == parData[1] && parData[2] == parData[3]
		&& parData[4] == parData[5] && parData[6] == parData[7])
		else $error("parallel pair driven unequal");
endmodule

bind terminal_diagnostic_self_test self_test_checker #(
	.CHAR_PHASE_CYCLES(CHAR_PHASE_CYCLES),
	.BEEP_CYCLES(BEEP_CYCLES)
) chk_u (.clk(clk), .rst_n(rst_n), .setupMode(setupMode), .startReq(startReq),
	.stopReq(stopReq), .running(running), .failed(failed), .errCode(errCode), .beep(beep),
	.attrPattern(attrPattern), .txd(txd), .parData(parData));
`default_nettype wire

// ### dv/tb_top.sv
// Self-checking testbench for the self-test sequencer
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	localparam logic [63:0] PHASE = 64'h7D0;
	localparam logic [31:0] BEEPN = 32'h14;
	logic        clk = 1'b0;
	logic        rst_n, setupMode, startReq, stopReq, running, failed, beep, attrPattern;
	logic        ramWe, txd, rts, dtr, rxd, cts, dcd, ackIn, busyIn, paperEmptyIn, errorIn;
	logic        oddPlug, stuckLvl, romBad;
	logic [1:0]  ramSel, badRam;
	logic [3:0]  breakPath;
	logic [7:0]  errCode, ramAddr, ramWdata, ramRdata, romData, parData, badAddr;
	logic [11:0] romAddr;
	logic [15:0] nvSignature;
	logic [7:0]  mem [0:2][0:255];
	int          errors = 0;
	int          compares = 0;
	int          cycles = 0;

	always #10 clk = ~clk;

	terminal_diagnostic_self_test #(.CHAR_PHASE_CYCLES(PHASE), .BEEP_CYCLES(BEEPN)) dut_u (
		.clk(clk), .rst_n(rst_n), .setupMode(setupMode), .startReq(startReq),
		.stopReq(stopReq), .running(running), .failed(failed), .errCode(errCode),
		.beep(beep), .attrPattern(attrPattern), .ramSel(ramSel), .ramWe(ramWe),
		.ramAddr(ramAddr), .ramWdata(ramWdata), .ramRdata(ramRdata), .romAddr(romAddr),
		.romData(romData), .nvSignature(nvSignature), .txd(txd), .rts(rts), .dtr(dtr),
		.rxd(rxd), .cts(cts), .dcd(dcd), .parData(parData), .ackIn(ackIn), .busyIn(busyIn),
		.paperEmptyIn(paperEmptyIn), .errorIn(errorIn));

	loopback_plug_model plug_u (.oddPlug(oddPlug), .breakPath(breakPath),
		.stuckLvl(stuckLvl), .txd(txd), .rts(rts), .dtr(dtr), .parData(parData), .rxd(rxd),
		.cts(cts), .dcd(dcd), .ackIn(ackIn), .busyIn(busyIn), .paperEmptyIn(paperEmptyIn),
		.errorIn(errorIn));

	// Display RAMs and code PROM, one cycle read latency; PROM bytes sum to 00
	always @(posedge clk) begin
		if (ramWe)
			mem[ramSel][ramAddr] <= ramWdata;
		ramRdata <= mem[ramSel][ramAddr] ^ {7'h0, ramSel == badRam && ramAddr == badAddr};
		romData <= romAddr[7:0] + {7'h0, romBad && romAddr == 12'h000};
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 115000) begin
			errors++;
			$display("FAIL t=%0t timeout", $time);
			test_done();
		end
	end

	function automatic logic [7:0] exp_code(input int k);
		logic [7:0] t [0:11];
		t = '{8'h78, 8'h41, 8'h63, 8'h64, 8'h62, 8'h63, 8'h61, 8'h30, 8'h31, 8'h32, 8'h50, 8'h4B};
		exp_code = t[k];
	endfunction

	task automatic check_bit(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("FAIL t=%0t flag %b expected %b", $time, got, exp);
		end
	endtask

	task automatic check_code(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("FAIL t=%0t code %h expected %h", $time, got, exp);
		end
	endtask

	task automatic start_test;
		@(posedge clk);
		startReq <= 1'b1;
		@(posedge clk);
		startReq <= 1'b0;
		@(negedge clk);
	endtask

	task automatic stop_test;
		@(posedge clk);
		stopReq <= 1'b1;
		@(posedge clk);
		stopReq <= 1'b0;
		@(negedge clk);
		check_bit(running | failed | attrPattern, 1'b0);
	endtask

	task automatic wait_fail(input int k);
		int n;
		n = 0;
		while (failed !== 1'b1 && n < 25000) begin
			@(negedge clk);
			n++;
		end
		check_code(errCode, exp_code(k));
		check_bit(beep && !running, 1'b1);
		repeat (BEEPN + 2) @(negedge clk);
		check_bit(beep, 1'b0);
		check_bit(failed, 1'b1);
		stop_test();
		$display("test fault %0d done", k);
	endtask

	task automatic test_done;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		rst_n = 1'b0;
		{setupMode, startReq, stopReq, oddPlug, stuckLvl, romBad} = 6'h00;
		nvSignature = 16'hA55A;
		breakPath = 4'hF;
		badRam = 2'h3;
		badAddr = 8'h00;
		void'($urandom(32'h0825));
		repeat (16) @(posedge clk);
		@(negedge clk);
		check_code({running, failed, beep, attrPattern, rts, dtr, !txd, ramWe}, 8'h00);
		@(posedge clk);
		rst_n <= 1'b1;
		start_test();
		check_bit(running, 1'b0);
		$display("test setup gate done");
		@(posedge clk);
		setupMode <= 1'b1;
		oddPlug <= 1'($urandom);
		start_test();
		check_bit(running, 1'b1);
		repeat (2100) @(negedge clk);
		check_bit(attrPattern, 1'b1);
		repeat (17000) @(negedge clk);
		// Past one full pass: still running proves the loop-back to the start
		check_bit(running & !failed, 1'b1);
		@(posedge clk);
		nvSignature <= 16'($urandom) & 16'h7FFF;
		wait_fail(11);
		@(posedge clk);
		nvSignature <= 16'hA55A;
		start_test();
		repeat (100) @(negedge clk);
		stop_test();
		$display("test long run and stop done");
		for (int k = 0; k < 11; k++) begin
			@(posedge clk);
			oddPlug <= 1'($urandom);
			stuckLvl <= 1'($urandom);
			breakPath <= (k < 7) ? 4'(k) : 4'hF;
			badRam <= (k >= 7 && k < 10) ? 2'(k - 7) : 2'h3;
			badAddr <= 8'($urandom);
			romBad <= (k == 10);
			start_test();
			wait_fail(k);
		end
		test_done();
	end
endmodule
`default_nettype wire
